// ---- logic/tim_bypass.sv ----
// two-frame pcm bypass delay line
`timescale 1ns/100ps
`include "tim_regs.svh"
module tim_bypass
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // frame and data
    input  wire logic              frame_tick,
    input  wire tim_pkg::tim_pcm_t pcm_in,
    output tim_pkg::tim_pcm_t      pcm_out
);
    import tim_pkg::*;
    typedef struct packed
    {
        tim_pcm_t [`TIM_BYP_DELAY:0] stage;
    } tim_byp_state_t;
    tim_byp_state_t st;
    tim_byp_state_t next_st;
    always_comb
    begin
        next_st = st;
        if (frame_tick)
        begin
            next_st.stage[0] = pcm_in;
            for (int i = 1; i <= `TIM_BYP_DELAY; i++)
            begin
                next_st.stage[i] = st.stage[i-1];
            end
        end
    end
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st <= '{stage: {(`TIM_BYP_DELAY+1){`TIM_PCM_RST}}};
        end
        else
        begin
            st <= next_st;
        end
    end
    // word captured in frame k leaves in frame k+2
    assign pcm_out = st.stage[`TIM_BYP_DELAY];
endmodule // tim_bypass

// ---- logic/tim_group_ctrl.sv ----
// tone interrupt masking and power control for one canceller group
`timescale 1ns/100ps
`include "tim_regs.svh"
module tim_group_ctrl
#(
    parameter bit IS_GROUP0 = 1'b1
)
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // control bits
    input  wire logic              global_tone_irq_mask,
    input  wire logic              canceller_a_tone_irq_mask,
    input  wire logic              canceller_b_tone_irq_mask,
    input  wire logic              group_power_on,
    // tone detector events from the cancellers
    input  wire logic              tone_det_a,
    input  wire logic              tone_det_b,
    // pcm frame and data
    input  wire logic              frame_tick,
    input  wire tim_pkg::tim_pcm_t recv_pcm_in,
    input  wire tim_pkg::tim_pcm_t send_pcm_in,
    input  wire tim_pkg::tim_pcm_t recv_pcm_proc,
    input  wire tim_pkg::tim_pcm_t send_pcm_proc,
    output tim_pkg::tim_pcm_t      recv_pcm_out,
    output tim_pkg::tim_pcm_t      send_pcm_out,
    // detector and canceller control
    output logic                   tone_det_a_status,
    output logic                   tone_det_b_status,
    output logic                   tone_irq,
    output logic                   cancellers_enable,
    output logic                   group_init,
    output logic                   coef_clear,
    output logic                   global_mask_active
);
    import tim_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed
    {
        logic     sync_a1;
        logic     sync_a2;
        logic     sync_b1;
        logic     sync_b2;
        logic     det_a;
        logic     det_b;
        logic     irq;
        logic     pwr_prev;
        logic     gmask;
        logic     enable;
        logic     init;
        logic     clear;
        logic [1:0] init_cnt;
        tim_pwr_t pwr;
        tim_pcm_t recv_out;
        tim_pcm_t send_out;
    } tim_state_t;
    tim_state_t st;
    tim_state_t next_st;
    tim_pcm_t   recv_byp;
    tim_pcm_t   send_byp;
    ////////////////////////////////////////////////////////////////////////////
    // power-down bypass paths
    tim_bypass u_recv_byp
    (
        .clk        (clk),
        .rst_n      (rst_n),
        .frame_tick (frame_tick),
        .pcm_in     (recv_pcm_in),
        .pcm_out    (recv_byp)
    );
    tim_bypass u_send_byp
    (
        .clk        (clk),
        .rst_n      (rst_n),
        .frame_tick (frame_tick),
        .pcm_in     (send_pcm_in),
        .pcm_out    (send_byp)
    );
    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_st = st;
        next_st.sync_a1 = tone_det_a;
        next_st.sync_a2 = st.sync_a1;
        next_st.sync_b1 = tone_det_b;
        next_st.sync_b2 = st.sync_b1;
        // only group 0 carries the global mask
        next_st.gmask = IS_GROUP0 ? global_tone_irq_mask : 1'b0;
        // detection status runs whatever the masks say
        next_st.det_a = st.sync_a2 & (st.pwr != TIM_OFF);
        next_st.det_b = st.sync_b2 & (st.pwr != TIM_OFF);
        next_st.irq = ~st.gmask
                    & ((st.det_b & ~canceller_b_tone_irq_mask)
                    | (st.det_a & ~canceller_a_tone_irq_mask));
        next_st.pwr_prev = group_power_on;
        next_st.init = 1'b0;
        next_st.clear = 1'b0;
        case (st.pwr)
            TIM_OFF:
            begin
                if (group_power_on && !st.pwr_prev)
                begin
                    next_st.pwr = TIM_INIT;
                    next_st.init = 1'b1;
                    next_st.clear = 1'b1;
                    next_st.init_cnt = 2'(`TIM_INIT_FRAMES);
                end
            end
            TIM_INIT:
            begin
                if (!group_power_on)
                begin
                    next_st.pwr = TIM_OFF;
                end
                else if (frame_tick)
                begin
                    if (st.init_cnt == 2'h1)
                    begin
                        next_st.pwr = TIM_RUN;
                    end
                    next_st.init_cnt = st.init_cnt - 2'h1;
                end
            end
            TIM_RUN:
            begin
                if (!group_power_on)
                begin
                    next_st.pwr = TIM_OFF;
                end
            end
            default:
            begin
                next_st.pwr = TIM_OFF;
            end
        endcase
        next_st.enable = (next_st.pwr == TIM_RUN);
        if (st.pwr == TIM_RUN)
        begin
            next_st.recv_out = recv_pcm_proc;
            next_st.send_out = send_pcm_proc;
        end
        else
        begin
            next_st.recv_out = recv_byp;
            next_st.send_out = send_byp;
        end
    end
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st <= '{pwr: TIM_OFF, recv_out: `TIM_PCM_RST, send_out: `TIM_PCM_RST,
                    init_cnt: 2'h0, default: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    assign recv_pcm_out       = st.recv_out;
    assign send_pcm_out       = st.send_out;
    assign tone_det_a_status  = st.det_a;
    assign tone_det_b_status  = st.det_b;
    assign tone_irq           = st.irq;
    assign cancellers_enable  = st.enable;
    assign group_init         = st.init;
    assign coef_clear         = st.clear;
    assign global_mask_active = st.gmask;
endmodule // tim_group_ctrl

// ---- logic/tim_pkg.sv ----
// types for the tone interrupt mask and group power control
`include "tim_regs.svh"
package tim_pkg;
    typedef logic [`TIM_PCM_W-1:0] tim_pcm_t;
    typedef enum logic [2:0]
    {
        TIM_OFF  = 3'b001,
        TIM_INIT = 3'b010,
        TIM_RUN  = 3'b100
    } tim_pwr_t;
endpackage

// ---- logic/tim_regs.svh ----
// constants for the tone interrupt mask and group power control
// Notes on behaviour
// - global mask set blocks every group 0 tone interrupt; clear lets them through
// - global masking never stops detection; detectors run whenever group power is not off
// - only group 0 holds the global mask bit; other groups lack it
// - canceller B mask set blocks that group's B tone interrupt; clear passes it
// - masked B detector keeps detecting; only its interrupt is suppressed
`ifndef TIM_REGS_SVH
`define TIM_REGS_SVH
`define TIM_PCM_W        8
`define TIM_PCM_RST      8'hFF
`define TIM_BYP_DELAY    2
`define TIM_INIT_FRAMES  2
`define TIM_CTRL_RST     8'h00
`endif

// ---- verif/tim_group_ctrl_asserts.sv ----
// assertions for the tone irq mask and power control
`timescale 1ns/100ps
module tim_group_ctrl_asserts
#(
    parameter bit IS_GROUP0 = 1'b1
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic global_tone_irq_mask,
    input wire logic canceller_a_tone_irq_mask,
    input wire logic canceller_b_tone_irq_mask,
    input wire logic group_power_on,
    input wire logic tone_det_a,
    input wire logic tone_det_b,
    input wire logic tone_det_a_status,
    input wire logic tone_det_b_status,
    input wire logic tone_irq,
    input wire logic cancellers_enable,
    input wire logic group_init,
    input wire logic coef_clear,
    input wire logic global_mask_active
);
    logic cause;
    always_ff @(posedge clk)
        cause <= !global_mask_active && (tone_det_a_status && !canceller_a_tone_irq_mask
            || tone_det_b_status && !canceller_b_tone_irq_mask);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_GLOBAL_MASK: assert property ((IS_GROUP0 && global_tone_irq_mask)[*4] |-> !tone_irq)
        else $error("tone irq under global mask");
    AST_GROUP0_ONLY: assert property ($stable(global_tone_irq_mask)[*2] |->
        global_mask_active == (IS_GROUP0 && global_tone_irq_mask)) else $error("global mask");
    AST_IRQ_CAUSE: assert property (tone_irq == cause)
        else $error("tone irq cause");
    AST_DET_A_RUNS: assert property (cancellers_enable && $past(cancellers_enable, 3) |->
        tone_det_a_status == $past(tone_det_a, 3)) else $error("detector a stalled");
    AST_DET_B_RUNS: assert property (cancellers_enable && $past(cancellers_enable, 3) |->
        tone_det_b_status == $past(tone_det_b, 3)) else $error("detector b stalled");
    AST_INIT_ON_RISE: assert property (group_init |-> coef_clear &&
        $past(group_power_on) && !$past(group_power_on, 2)) else $error("init pulse");
    AST_OFF_QUIET: assert property (!group_power_on[*3] |-> !cancellers_enable &&
        !tone_det_b_status) else $error("group awake while off");
endmodule // tim_group_ctrl_asserts
bind tim_group_ctrl tim_group_ctrl_asserts #(.IS_GROUP0(IS_GROUP0)) chk_u
(
    .clk, .rst_n, .global_tone_irq_mask, .canceller_a_tone_irq_mask,
    .canceller_b_tone_irq_mask, .group_power_on, .tone_det_a, .tone_det_b,
    .tone_det_a_status, .tone_det_b_status, .tone_irq, .cancellers_enable,
    .group_init, .coef_clear, .global_mask_active
);

// ---- verif/tim_group_ctrl_tb.sv ----
// bench for the tone irq mask and power control
`timescale 1ns/100ps
module tim_group_ctrl_tb;
    import tim_pkg::*;
    logic clk, rst_n, gm, ma, mb, pw, da, db, ft, sa, sb, irq, en, gi, cc, gma;
    tim_pcm_t ri, si, rp, sp, ro, so, q[$];
    logic [7:0] n;
    logic [15:0] p;
    logic g1_gma, g1_irq;
    bit [31:0] r = 32'h6936;
    bit [4:0] h[512];
    int err_count, n_tests;
    tim_group_ctrl dut_u
    (
        .clk, .rst_n, .global_tone_irq_mask(gm), .canceller_a_tone_irq_mask(ma),
        .canceller_b_tone_irq_mask(mb), .group_power_on(pw), .tone_det_a(da),
        .tone_det_b(db), .frame_tick(ft), .recv_pcm_in(ri), .send_pcm_in(si),
        .recv_pcm_proc(rp), .send_pcm_proc(sp), .recv_pcm_out(ro), .send_pcm_out(so),
        .tone_det_a_status(sa), .tone_det_b_status(sb), .tone_irq(irq),
        .cancellers_enable(en), .group_init(gi), .coef_clear(cc), .global_mask_active(gma)
    );
    tim_group_ctrl #(.IS_GROUP0(1'b0)) dut1_u
    (
        .clk, .rst_n, .global_tone_irq_mask(gm), .canceller_a_tone_irq_mask(ma),
        .canceller_b_tone_irq_mask(mb), .group_power_on(pw), .tone_det_a(da),
        .tone_det_b(db), .frame_tick(ft), .recv_pcm_in(ri), .send_pcm_in(si),
        .recv_pcm_proc(rp), .send_pcm_proc(sp), .recv_pcm_out(), .send_pcm_out(),
        .tone_det_a_status(), .tone_det_b_status(), .tone_irq(g1_irq),
        .cancellers_enable(), .group_init(), .coef_clear(), .global_mask_active(g1_gma)
    );
    function automatic void step();
        r ^= r << 13;
        r ^= r >> 17;
        r ^= r << 5;
    endfunction
    task automatic chk(logic [7:0] g, logic [7:0] e);
        n_tests++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic finish_test();
        if (err_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        #40000 err_count++;
        finish_test();
    end
    initial
    begin
        {rst_n, gm, ma, mb, pw, ft, rp, sp} = '0;
        {da, db, ri, si} = '1;
        repeat (8) @(posedge clk);
        #2 rst_n = 1'h1;
        for (int i = 0; i < 40; i++)
        begin
            @(posedge clk);
            #2 ft = i % 4 == 0;
            step();
            if (ft)
                ri = r[7:0];
            si = ~ri;
            if (ft)
                q.push_back(ri);
            if (i % 4 == 3 && q.size() > 2)
            begin
                chk(ro, q[$-2]);
                chk(so, ~q[$-2]);
                chk(8'(sb), 8'h00);
            end
        end
        pw = 1'h1;
        n = 8'h00;
        repeat (4)
        begin
            @(posedge clk);
            #2 n += 8'(gi) + 8'(cc);
        end
        chk(n, 8'h02);
        for (int i = 0; i < 400; i++)
        begin
            @(posedge clk);
            #2;
            if (i > 12)
            begin
                chk(8'(sa), 8'(h[i-3][1]));
                chk(8'(sb), 8'(h[i-3][0]));
                chk(8'(irq), 8'(!h[i-2][4] && (h[i-4][1] && !h[i-1][3]
                    || h[i-4][0] && !h[i-1][2])));
                chk(8'(gma), 8'(h[i-1][4]));
                chk(8'(g1_gma), 8'h00);
                chk(8'(g1_irq), 8'(h[i-4][1] && !h[i-1][3]
                    || h[i-4][0] && !h[i-1][2]));
                chk(8'(en), 8'h01);
                chk(ro, p[15:8]);
                chk(so, p[7:0]);
            end
            step();
            gm ^= r[6:4] == 3'h0;
            {ma, mb, da, db} = r[3:0];
            {rp, sp} = r[23:8];
            p = r[23:8];
            ft = i % 4 == 0;
            h[i] = {gm, ma, mb, da, db};
        end
        finish_test();
    end
endmodule // tim_group_ctrl_tb
